// ### logic/tone_keying_params.svh
// Timing and sizing constants for the tone keying control pair.
// Assumes a 200 MHz system clock shared by both ends.
`ifndef TONE_KEYING_PARAMS_SVH
`define TONE_KEYING_PARAMS_SVH

`define CLK_PERIOD_PS        5000
// Delay times in nanoseconds
`define EXT_START_NS         1000
`define EXT_HOLD_NS          60000
`define ENV_START_NS         6000
`define ENV_STOP_MIN_NS      15000
`define ENV_STOP_MAX_NS      60000
// Envelope release delay chosen inside the allowed window
`define ENV_STOP_NS          30000
// Cycle counts derived from the times (start: round up, hold: round down)
`define EXT_START_CYC  ((`EXT_START_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define EXT_HOLD_CYC   ((`EXT_HOLD_NS * 1000) / `CLK_PERIOD_PS)
`define ENV_START_CYC  ((`ENV_START_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ENV_STOP_CYC   ((`ENV_STOP_NS * 1000) / `CLK_PERIOD_PS)
// Internal tone half period: 22 kHz -> 22727 ns per half cycle
`define TONE_HALF_NS         22727
`define TONE_HALF_CYC  ((`TONE_HALF_NS * 1000) / `CLK_PERIOD_PS)
`define CNT_W                14
`define SYNC_DEPTH           3

`endif

// ### logic/tone_keying_pkg.sv
// Types shared by both ends of the tone keying control pair.
// Assumes tone_keying_params.svh supplies all numeric constants.
package tone_keying_pkg;
    typedef enum logic [1:0] {
        MODE_CONT,
        MODE_ENVELOPE,
        MODE_EXTERNAL,
        MODE_OFF
    } tone_mode_t;
endpackage

// ### logic/tone_keying_if.sv
// Connection between the keying host and the tone keying device.
// Assumes one common clock; control bits are plain levels, no bus.
`timescale 1ns/1ps
`default_nettype none
interface tone_keying_if (
    input wire logic clk_sys_i
);
    logic external_tone_select;
    logic tone_on_bit;
    logic low_loss_mode_bit;
    logic tone_keying_input;

    modport host_mp (
        output external_tone_select,
        output tone_on_bit,
        output low_loss_mode_bit,
        output tone_keying_input
    );
    modport device_mp (
        input external_tone_select,
        input tone_on_bit,
        input low_loss_mode_bit,
        input tone_keying_input
    );
endinterface
`default_nettype wire

// ### logic/tone_keying_host.sv
// Host end: holds the control bits and drives the keying input.
// Assumes a user side that asks for a mode and keys bursts by level.
`timescale 1ns/1ps
`default_nettype none
`include "tone_keying_params.svh"
module tone_keying_host
    import tone_keying_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    tone_keying_if.host_mp   link,
    input  wire tone_mode_t  mode_req_i,
    input  wire logic        low_loss_req_i,
    input  wire logic        key_i,
    input  wire logic        ext_tone_i,
    output logic             mode_busy_o
);
    tone_mode_t mode_q, mode_d;
    logic       sel_q, sel_d, on_q, on_d, llm_q, llm_d, key_q, key_d;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        mode_d = mode_q;
        // Mode only changes while idle, avoiding clipped bursts
        if (!key_i && mode_req_i != mode_q) begin
            mode_d = mode_req_i;
        end
        sel_d = (mode_q == MODE_EXTERNAL);
        on_d  = (mode_q != MODE_OFF);
        // Low loss only when no tone can be present
        llm_d = low_loss_req_i && (mode_q == MODE_OFF) && !key_i;
        case (mode_q)
            MODE_CONT:     key_d = 1'b1;
            MODE_ENVELOPE: key_d = key_i && on_q;
            MODE_EXTERNAL: key_d = key_i && on_q && sel_q && ext_tone_i;
            default:       key_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mode_q <= MODE_OFF;
            sel_q  <= 1'b0;
            on_q   <= 1'b0;
            llm_q  <= 1'b0;
            key_q  <= 1'b0;
        end else begin
            mode_q <= mode_d;
            sel_q  <= sel_d;
            on_q   <= on_d;
            llm_q  <= llm_d;
            key_q  <= key_d;
        end
    end

    assign link.external_tone_select = sel_q;
    assign link.tone_on_bit          = on_q;
    assign link.low_loss_mode_bit    = llm_q;
    assign link.tone_keying_input    = key_q;
    assign mode_busy_o               = (mode_req_i != mode_q);
endmodule
`default_nettype wire

// ### logic/tone_keying_device.sv
// Device end: gates the internal 22 kHz tone, or in external mode the keying waveform, onto the supply output.
// What this block and the host do
// - External TTL tone needs select and on set
// - Envelope mode: select clear, on set
// - Continuous: keying high, select clear, on switches
// - Host keeps low loss clear during tone
// - Low loss reduces headroom only without tone
// - External mode follows keying frequency and duty
// - Host sets bits before driving external tone
// - External tone starts about 1 us after toggling
// - External tone holds about 60 us after toggling
// - Envelope: start 6 us, stop 15-60 us
// - Tone-on set before keying, cleared after; in continuous mode both switch on the same clock
// Assumes keying input arrives from a pin, bits from the host's logic.
`timescale 1ns/1ps
`default_nettype none
`include "tone_keying_params.svh"
module tone_keying_device
    import tone_keying_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    tone_keying_if.device_mp link,
    output logic             supply_output_o,
    output logic             tone_active_o,
    output logic             headroom_low_o
);
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_START,
        PH_TONE,
        PH_RELEASE
    } tone_state_t;

    ////////////////////////////////////////////////////////////////////
    // Keying pin synchroniser: stage 0 feeds only stage 1
    logic [`SYNC_DEPTH-1:0] sync_q, sync_d;
    logic                   key_q, key_d, prev_q, prev_d;
    logic                   key_edge;

    always_comb begin
        sync_d = {sync_q[`SYNC_DEPTH-2:0], link.tone_keying_input};
        prev_d = key_q;
        key_d  = key_q;
        // A change counts only once the last two stages agree
        if (sync_q[`SYNC_DEPTH-2] == sync_q[`SYNC_DEPTH-1]) begin
            key_d = sync_q[`SYNC_DEPTH-1];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sync_q <= '0;
            key_q  <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            key_q  <= key_d;
            prev_q <= prev_d;
        end
    end

    // Idle level of the pin is low, so no false edge follows reset
    assign key_edge = key_q ^ prev_q;

    ////////////////////////////////////////////////////////////////////
    // Activation and release timing
    // A mode change mid-burst is not guarded here; the host holds it off
    tone_state_t           ph_q, ph_d;
    logic [`CNT_W-1:0]     cnt_q, cnt_d;
    logic                  ext_mode;
    logic                  want;

    assign ext_mode = link.external_tone_select;
    // Envelope and continuous modes want tone while keying is high
    assign want = ext_mode ? key_edge : key_q;

    always_comb begin
        ph_d  = ph_q;
        cnt_d = cnt_q;
        case (ph_q)
            PH_IDLE: begin
                if (want) begin
                    ph_d  = PH_START;
                    cnt_d = ext_mode ? `CNT_W'(`EXT_START_CYC - 1)
                                     : `CNT_W'(`ENV_START_CYC - 1);
                end
            end
            PH_START: begin
                // A short envelope blip aborts rather than leaving a stub burst
                if (!ext_mode && !key_q) begin
                    ph_d = PH_IDLE;
                end else if (cnt_q == '0) begin
                    ph_d  = PH_TONE;
                    cnt_d = `CNT_W'(`EXT_HOLD_CYC - 1);
                end else begin
                    cnt_d = cnt_q - `CNT_W'(1);
                end
            end
            PH_TONE: begin
                if (ext_mode) begin
                    // Each toggle rearms the hold, so a gap stops it
                    if (key_edge) begin
                        cnt_d = `CNT_W'(`EXT_HOLD_CYC - 1);
                    end else if (cnt_q == '0) begin
                        ph_d = PH_IDLE;
                    end else begin
                        cnt_d = cnt_q - `CNT_W'(1);
                    end
                end else if (!key_q) begin
                    ph_d  = PH_RELEASE;
                    cnt_d = `CNT_W'(`ENV_STOP_CYC - 1);
                end
            end
            PH_RELEASE: begin
                if (key_q) begin
                    ph_d = PH_TONE;
                end else if (cnt_q == '0) begin
                    ph_d = PH_IDLE;
                end else begin
                    cnt_d = cnt_q - `CNT_W'(1);
                end
            end
            default: begin
                ph_d = PH_IDLE;
            end
        endcase
        // Tone-on clear forces silence at once
        if (!link.tone_on_bit) begin
            ph_d  = PH_IDLE;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ph_q  <= PH_IDLE;
            cnt_q <= '0;
        end else begin
            ph_q  <= ph_d;
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Internal 22 kHz generator
    // Held at the start of a high half while silent, so every burst
    // opens with a full half period instead of a random fragment
    logic [`CNT_W-1:0] half_q, half_d;
    logic              gen_q, gen_d;
    logic              active;
    logic              act_d;

    assign active = (ph_q == PH_TONE) || (ph_q == PH_RELEASE);
    assign act_d  = active && link.tone_on_bit;

    always_comb begin
        half_d = half_q;
        gen_d  = gen_q;
        if (!act_d) begin
            half_d = `CNT_W'(`TONE_HALF_CYC - 1);
            gen_d  = 1'b1;
        end else if (half_q == '0) begin
            half_d = `CNT_W'(`TONE_HALF_CYC - 1);
            gen_d  = !gen_q;
        end else begin
            half_d = half_q - `CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            half_q <= `CNT_W'(`TONE_HALF_CYC - 1);
            gen_q  <= 1'b1;
        end else begin
            half_q <= half_d;
            gen_q  <= gen_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registered outputs
    logic              out_q, out_d, act_q, low_q, low_d;

    always_comb begin
        // External mode copies the keying waveform edges and duty
        // Envelope and continuous fill with the internal tone
        out_d = act_d && (ext_mode ? key_q : gen_q);
        // Headroom reduced only with low loss set and no tone; tone wins
        low_d = link.low_loss_mode_bit && !act_d;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            out_q  <= 1'b0;
            act_q  <= 1'b0;
            low_q  <= 1'b0;
        end else begin
            out_q  <= out_d;
            act_q  <= act_d;
            low_q  <= low_d;
        end
    end

    assign supply_output_o = out_q;
    assign tone_active_o   = act_q;
    assign headroom_low_o  = low_q;
endmodule
`default_nettype wire

// ### bench/tone_keying_props.sv
// Checker for the control link between host and device.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tone_keying_props (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic external_tone_select,
    input wire logic tone_on_bit,
    input wire logic low_loss_mode_bit,
    input wire logic tone_keying_input
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    AST_LL_NO_TONE: assert property (tone_on_bit |-> !low_loss_mode_bit)
        else $error("low loss set with tone on");
    AST_EXT_NEEDS_ON: assert property (external_tone_select |-> tone_on_bit)
        else $error("external select without tone on");
    AST_KEY_AFTER_ON: assert property ($rose(tone_keying_input) |-> ##[0:1] tone_on_bit)
        else $error("keying began without tone on");
    AST_SEL_HELD: assert property (external_tone_select && tone_keying_input |=> external_tone_select)
        else $error("select dropped while keying");
    AST_LL_RISE: assert property ($rose(low_loss_mode_bit) |-> !tone_on_bit)
        else $error("low loss rose with tone on");
    AST_RESET_QUIET: assert property ($fell(rst_i) |-> !tone_on_bit && !external_tone_select)
        else $error("control bits set after reset");
    AST_EXT_KEY_QUIET: assert property ($rose(external_tone_select) |-> !tone_keying_input)
        else $error("tone driven before bits set");
    AST_OFF_CLEARS_SEL: assert property ($fell(tone_on_bit) |-> !external_tone_select)
        else $error("select left set with tone off");
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench: host and device joined by the link interface.
// Assumes the cycle counts of the shared timing header.
`timescale 1ns/1ps
`default_nettype none
module tb
    import tone_keying_pkg::*;
;
    logic       clk_sys_i = 1'b0;
    logic       rst_i     = 1'b1;
    tone_mode_t mode_req  = MODE_OFF;
    logic       ll_req    = 1'b0;
    logic       key       = 1'b0;
    logic       ext_tone  = 1'b0;
    logic       busy, supply, active, headroom;
    int         num_errors = 0;
    int         checks     = 0;
    int         n;
    always #2.5 clk_sys_i = ~clk_sys_i;
    tone_keying_if u_tone_keying_if (.clk_sys_i(clk_sys_i));
    tone_keying_host u_tone_keying_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .link(u_tone_keying_if.host_mp), .mode_req_i(mode_req), .low_loss_req_i(ll_req),
        .key_i(key), .ext_tone_i(ext_tone), .mode_busy_o(busy));
    tone_keying_device u_tone_keying_device (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .link(u_tone_keying_if.device_mp), .supply_output_o(supply),
        .tone_active_o(active), .headroom_low_o(headroom));
    tone_keying_props u_tone_keying_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .external_tone_select(u_tone_keying_if.external_tone_select),
        .tone_on_bit(u_tone_keying_if.tone_on_bit),
        .low_loss_mode_bit(u_tone_keying_if.low_loss_mode_bit),
        .tone_keying_input(u_tone_keying_if.tone_keying_input));
    ////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic drive(input tone_mode_t m, input logic l, input logic k);
        @(posedge clk_sys_i);
        mode_req <= m;
        ll_req   <= l;
        key      <= k;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge clk_sys_i);
    endtask
    // Counts cycles until the tone flag reaches v; a hang ends the run
    task automatic wait_act(input logic v, input int max, output int c);
        c = 0;
        while (active !== v && c < max) begin
            @(negedge clk_sys_i);
            c++;
        end
        if (c >= max) begin
            num_errors++;
            close_out();
        end
    endtask
    // Counts cycles until the tone output reaches v; a hang ends the run
    task automatic wait_sup(input logic v, input int max, output int c);
        c = 0;
        while (supply !== v && c < max) begin
            @(negedge clk_sys_i);
            c++;
        end
        if (c >= max) begin
            num_errors++;
            close_out();
        end
    endtask
    task automatic bits(input logic s, input logic o);
        chk(u_tone_keying_if.external_tone_select, s);
        chk(u_tone_keying_if.tone_on_bit, o);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_off();
        drive(MODE_OFF, 1'b0, 1'b1);
        cyc(1500);
        chk(active, 1'b0);
        chk(supply, 1'b0);
        drive(MODE_OFF, 1'b1, 1'b0);
        cyc(4);
        chk(u_tone_keying_if.low_loss_mode_bit, 1'b1);
        chk(headroom, 1'b1);
        $display("test off done");
    endtask
    task automatic t_cont();
        drive(MODE_CONT, 1'b1, 1'b0);
        wait_act(1'b1, 1400, n);
        chk_n(n, 1200, 1215);
        chk(supply, 1'b1);
        wait_sup(1'b0, 4700, n);
        chk_n(n, 4540, 4550);
        wait_sup(1'b1, 4700, n);
        chk_n(n, 4540, 4550);
        bits(1'b0, 1'b1);
        chk(u_tone_keying_if.tone_keying_input, 1'b1);
        chk(u_tone_keying_if.low_loss_mode_bit, 1'b0);
        chk(headroom, 1'b0);
        drive(MODE_OFF, 1'b0, 1'b0);
        wait_act(1'b0, 8, n);
        bits(1'b0, 1'b0);
        $display("test continuous done");
    endtask
    task automatic t_env();
        drive(MODE_ENVELOPE, 1'b0, 1'b0);
        cyc(4);
        bits(1'b0, 1'b1);
        drive(MODE_ENVELOPE, 1'b0, 1'b1);
        wait_act(1'b1, 1400, n);
        chk_n(n, 1200, 1215);
        wait_sup(1'b0, 4700, n);
        chk_n(n, 4540, 4550);
        drive(MODE_OFF, 1'b0, 1'b1);
        cyc(3);
        chk(busy, 1'b1);
        bits(1'b0, 1'b1);
        drive(MODE_ENVELOPE, 1'b0, 1'b0);
        wait_act(1'b0, 13000, n);
        chk_n(n, 3000, 12000);
        $display("test envelope done");
    endtask
    task automatic t_ext();
        drive(MODE_EXTERNAL, 1'b0, 1'b0);
        cyc(4);
        bits(1'b1, 1'b1);
        drive(MODE_EXTERNAL, 1'b0, 1'b1);
        @(posedge clk_sys_i);
        ext_tone <= 1'b1;
        wait_act(1'b1, 400, n);
        chk_n(n, 200, 215);
        @(posedge clk_sys_i);
        ext_tone <= 1'b0;
        cyc(50);
        chk(supply, 1'b0);
        @(posedge clk_sys_i);
        ext_tone <= 1'b1;
        cyc(50);
        chk(supply, 1'b1);
        @(posedge clk_sys_i);
        ext_tone <= 1'b0;
        wait_act(1'b0, 12100, n);
        chk_n(n, 12000, 12020);
        drive(MODE_OFF, 1'b0, 1'b0);
        $display("test external done");
    endtask
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_off();
        t_cont();
        t_env();
        t_ext();
        close_out();
    end
endmodule
`default_nettype wire
